// [shared/cls_pkg.sv]
// constants for the compare / logic / status-op execution slice
// assumes an 8-bit processor core around it that owns the other opcodes
package cls_pkg;
  localparam int unsigned CLS_CLK_NS        = 25;
  localparam int unsigned CLS_PERIODS_CYC   = 3;
  // opcode groups, upper six bits of the first byte; clear and halt are full bytes
  localparam logic [5:0]  CLS_OP_COMPARE_Z  = 6'h38;
  localparam logic [5:0]  CLS_OP_DECADJ     = 6'h25;
  localparam logic [5:0]  CLS_OP_XOR_Z      = 6'h08;
  localparam logic [5:0]  CLS_OP_XOR_I      = 6'h09;
  localparam logic [5:0]  CLS_OP_XOR_R      = 6'h0a;
  localparam logic [5:0]  CLS_OP_XOR_A      = 6'h0b;
  localparam logic [5:0]  CLS_OP_OR_Z       = 6'h18;
  localparam logic [5:0]  CLS_OP_OR_I       = 6'h19;
  localparam logic [5:0]  CLS_OP_OR_R       = 6'h1a;
  localparam logic [5:0]  CLS_OP_OR_A       = 6'h1b;
  localparam logic [7:0]  CLS_OP_CLR_UPPER  = 8'h74;
  localparam logic [7:0]  CLS_OP_CLR_LOWER  = 8'h75;
  localparam logic [7:0]  CLS_OP_HALT       = 8'h40;
  // cycle counts per instruction
  localparam logic [2:0]  CLS_CYC_2         = 3'h2;
  localparam logic [2:0]  CLS_CYC_3         = 3'h3;
  localparam logic [2:0]  CLS_CYC_4         = 3'h4;
  // lower status byte fields
  localparam int unsigned CLS_PSL_CC_HI     = 7;
  localparam int unsigned CLS_PSL_CC_LO     = 6;
  localparam int unsigned CLS_PSL_IDC       = 5;
  localparam int unsigned CLS_PSL_COM       = 1;
  localparam int unsigned CLS_PSL_C         = 0;
  localparam logic [1:0]  CLS_CC_POS        = 2'h1;
  localparam logic [1:0]  CLS_CC_ZERO       = 2'h0;
  localparam logic [1:0]  CLS_CC_NEG        = 2'h2;
  // decimal adjust addends by {carry, interdigit}
  localparam logic [7:0]  CLS_DA_00         = 8'haa;
  localparam logic [7:0]  CLS_DA_01         = 8'ha0;
  localparam logic [7:0]  CLS_DA_10         = 8'h0a;
  localparam logic [7:0]  CLS_DA_11         = 8'h00;
  // upper byte bits 4 and 3 unassigned
  localparam logic [7:0]  CLS_PSU_USED      = 8'he7;
  localparam logic [7:0]  CLS_PSL_RESET     = 8'h00;
  localparam logic [7:0]  CLS_PSU_RESET     = 8'h00;

  typedef enum logic [1:0] {CLS_OPD_NONE, CLS_OPD_IMM, CLS_OPD_MEM} cls_opd_e;
endpackage : cls_pkg

// [shared/cls_alu_if.sv]
// carrier between sequencer and the combinational alu
// assumes both ends share one clock domain
`timescale 1ns/1ps
interface cls_alu_if;
  logic [7:0] opc;
  logic [7:0] reg_a;
  logic [7:0] reg_b;
  logic [7:0] operand;
  logic [7:0] psl;
  logic [7:0] result;
  logic [1:0] cc;
  modport seq (output opc, output reg_a, output reg_b, output operand, output psl,
               input result, input cc);
  modport alu (input opc, input reg_a, input reg_b, input operand, input psl,
               output result, output cc);
endinterface : cls_alu_if

// [hdl/cls_alu.sv]
// combinational datapath: xor, or, compare, decimal adjust
// assumes the sequencer presents stable operands in the write cycle
`timescale 1ns/1ps
module cls_alu
  import cls_pkg::*;
(
  cls_alu_if.alu a
);
  function automatic logic [1:0] cls_sign_cc(input logic [7:0] v);
    if (v == 8'h00)
      return CLS_CC_ZERO;
    return v[7] ? CLS_CC_NEG : CLS_CC_POS;
  endfunction : cls_sign_cc

  logic [7:0] da_add;
  logic       gt;
  always_comb
  begin
    unique case ({a.psl[CLS_PSL_C], a.psl[CLS_PSL_IDC]})
      2'b00: da_add = CLS_DA_00;
      2'b01: da_add = CLS_DA_01;
      2'b10: da_add = CLS_DA_10;
      default: da_add = CLS_DA_11;
    endcase
    // unsigned when mode bit set, signed otherwise
    if (a.psl[CLS_PSL_COM])
      gt = a.reg_a > a.reg_b;
    else
      gt = $signed(a.reg_a) > $signed(a.reg_b);
    a.result = a.reg_a;
    a.cc     = cls_sign_cc(a.reg_a);
    if (a.opc[7:2] == CLS_OP_COMPARE_Z)
    begin
      a.cc = (a.reg_a == a.reg_b) ? CLS_CC_ZERO : (gt ? CLS_CC_POS : CLS_CC_NEG);
    end
    else if (a.opc[7:2] == CLS_OP_DECADJ)
    begin
      // nibbles add independently, no carry between them
      a.result = {a.reg_a[7:4] + da_add[7:4], a.reg_a[3:0] + da_add[3:0]};
      a.cc     = cls_sign_cc(a.result);
    end
    else if (a.opc[6])
    begin
      a.result = a.reg_a | a.operand;
      a.cc     = cls_sign_cc(a.result);
    end
    else
    begin
      a.result = a.reg_a ^ a.operand;
      a.cc     = cls_sign_cc(a.result);
    end
  end
endmodule : cls_alu

// [hdl/cls_core.sv]
// execution slice: decode, multi-cycle sequencing, register and status update
// assumes program memory answers a fetch request in the same cycle; one
// cycle here is one processor cycle (three periods of the processor clock)
//
// Behaviour
// - compare-z E0-E3, two cycles, cc only
// - compare cc 01 greater, 00 equal, 10 less
// - compare mode selected by status mode bit
// - mode one unsigned, zero signed
// - clear-lower 75, three cycles, masked clear
// - clear-upper 74, three cycles, masked clear
// - mask one clears bit, zero keeps
// - decimal adjust 94-97 adds ten per nibble
// - addend AA, A0, 0A, 00 by carries
// - decimal adjust keeps carry and interdigit carry
// - decimal adjust cc from signed result
// - xor absolute 2C-2F, four cycles, memory byte
// - indexed absolute: index from low bits, dest r0
// - xor immediate 24-27, two cycles
// - xor relative 28-2B, three cycles
// - xor-z 20-23 writes r0, r unchanged
// - logic ops set cc by sign
// - halt 40, two cycles, enters wait
// - leave wait only on reset or interrupt
// - or absolute 6C-6F, four cycles
// - or immediate two cycles, second byte
// - or relative decoded from 68-6B
`timescale 1ns/1ps
module cls_core
  import cls_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // instruction and operand fetch
  input  wire logic        start,
  input  wire logic [7:0]  opcode,
  input  wire logic        indexed,
  output logic             fetch_req,
  input  wire logic [7:0]  fetch_data,
  // interrupt wake from wait
  input  wire logic        irq,
  // architectural state
  output logic [7:0]       reg0,
  output logic [7:0]       reg1,
  output logic [7:0]       reg2,
  output logic [7:0]       reg3,
  output logic [7:0]       lower_status,
  output logic [7:0]       upper_status_byte,
  // status
  output logic             busy,
  output logic             done,
  output logic             running,
  output logic             illegal
);
  typedef enum logic [1:0] {CLS_IDLE, CLS_EXEC, CLS_WAIT} cls_state_e;

  // xor/or to register zero: second operand from the file, never fetched
  function automatic logic cls_is_z(input logic [7:0] op);
    return op[7:2] == CLS_OP_XOR_Z || op[7:2] == CLS_OP_OR_Z;
  endfunction : cls_is_z

  // any xor or or form, all four addressing modes
  function automatic logic cls_is_logic(input logic [7:0] op);
    return op[7:4] == CLS_OP_XOR_Z[5:2] || op[7:4] == CLS_OP_OR_Z[5:2];
  endfunction : cls_is_logic

  function automatic logic [1:0] cls_cc_of(input logic [7:0] v);
    if (v == 8'h00)
      return CLS_CC_ZERO;
    return v[7] ? CLS_CC_NEG : CLS_CC_POS;
  endfunction : cls_cc_of

  cls_state_e  state_q;
  logic [7:0]  opc_q;
  logic        idx_q;
  logic [2:0]  cnt_q;
  logic [2:0]  len_q;
  logic [7:0]  opd_q;
  logic [7:0]  regs_q [4];
  logic [7:0]  psl_q;
  logic [7:0]  psu_q;
  logic        done_q;
  logic        ill_q;
  cls_opd_e    kind_d;
  logic [2:0]  len_d;
  logic        legal_d;
  logic        last;
  logic [1:0]  dst;
  logic [1:0]  rsel;

  cls_alu_if aif ();
  cls_alu u_alu (.a(aif.alu));

  // decode length and operand kind from the first byte
  always_comb
  begin
    legal_d = 1'b1;
    kind_d  = CLS_OPD_NONE;
    len_d   = CLS_CYC_2;
    if (opcode[7:2] == CLS_OP_COMPARE_Z || opcode[7:2] == CLS_OP_XOR_Z
        || opcode[7:2] == CLS_OP_OR_Z || opcode == CLS_OP_HALT)
      len_d = CLS_CYC_2;
    else if (opcode[7:2] == CLS_OP_DECADJ)
      len_d = CLS_CYC_3;
    else if (opcode[7:2] == CLS_OP_XOR_I || opcode[7:2] == CLS_OP_OR_I)
    begin
      kind_d = CLS_OPD_IMM;
      len_d  = CLS_CYC_2;
    end
    else if (opcode[7:2] == CLS_OP_XOR_R || opcode[7:2] == CLS_OP_OR_R)
    begin
      kind_d = CLS_OPD_MEM;
      len_d  = CLS_CYC_3;
    end
    else if (opcode[7:2] == CLS_OP_XOR_A || opcode[7:2] == CLS_OP_OR_A)
    begin
      kind_d = CLS_OPD_MEM;
      len_d  = CLS_CYC_4;
    end
    else if (opcode == CLS_OP_CLR_LOWER || opcode == CLS_OP_CLR_UPPER)
    begin
      kind_d = CLS_OPD_IMM;
      len_d  = CLS_CYC_3;
    end
    else
      legal_d = 1'b0;
  end

  assign last = (state_q == CLS_EXEC) && (cnt_q == len_q);
  // indexed absolute forms steer the result into register zero
  assign dst  = (opc_q[7:2] == CLS_OP_COMPARE_Z || cls_is_z(opc_q)
                 || (idx_q && opc_q[3:2] == 2'b11))
                ? 2'h0 : opc_q[1:0];
  assign rsel = opc_q[1:0];

  assign aif.opc     = opc_q;
  assign aif.reg_a   = (opc_q[7:2] == CLS_OP_COMPARE_Z || cls_is_z(opc_q))
                       ? regs_q[0] : regs_q[dst];
  assign aif.reg_b   = regs_q[rsel];
  // immediate forms share the upper opcode bits, so decode the full group
  assign aif.operand = cls_is_z(opc_q) ? regs_q[rsel] : opd_q;
  assign aif.psl     = psl_q;

  // sequencing
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_q <= CLS_IDLE;
      opc_q   <= 8'h00;
      idx_q   <= 1'b0;
      cnt_q   <= 3'h0;
      len_q   <= CLS_CYC_2;
    end
    else
    begin
      unique case (state_q)
        CLS_IDLE:
          if (start && legal_d)
          begin
            state_q <= CLS_EXEC;
            opc_q   <= opcode;
            idx_q   <= indexed && opcode[3:2] == 2'b11 && kind_d == CLS_OPD_MEM;
            len_q   <= len_d;
            cnt_q   <= 3'h1;
          end
        CLS_EXEC:
          if (last)
            state_q <= (opc_q == CLS_OP_HALT) ? CLS_WAIT : CLS_IDLE;
          else
            cnt_q <= cnt_q + 3'h1;
        CLS_WAIT:
          if (irq)
            state_q <= CLS_IDLE;
      endcase
    end
  end

  // operand byte latched at the end of the request cycle
  always_ff @(posedge clk)
  begin
    if (!resetn)
      opd_q <= 8'h00;
    else if (state_q == CLS_EXEC && fetch_req)
      opd_q <= fetch_data;
  end

  // the operand byte is requested the cycle before completion; compare and
  // register-zero forms must not fetch, or memory would lose a byte
  assign fetch_req = (state_q == CLS_EXEC) && !cls_is_z(opc_q) && (opc_q[7:2] != CLS_OP_COMPARE_Z)
                     && (opc_q[7:2] != CLS_OP_DECADJ) && (opc_q != CLS_OP_HALT)
                     && (cnt_q == len_q - 3'h1);

  // register file write
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 4; i++)
        regs_q[i] <= 8'h00;
    end
    else if (last && opc_q != CLS_OP_HALT && opc_q[7:1] != 7'h3a && opc_q[7:2] != CLS_OP_COMPARE_Z)
      regs_q[dst] <= aif.result;
  end

  // status bytes
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      psl_q <= CLS_PSL_RESET;
      psu_q <= CLS_PSU_RESET;
    end
    else if (last)
    begin
      if (opc_q == CLS_OP_CLR_LOWER)
        psl_q <= psl_q & ~opd_q;
      else if (opc_q == CLS_OP_CLR_UPPER)
        psu_q <= psu_q & ~opd_q & CLS_PSU_USED;
      else if (opc_q != CLS_OP_HALT)
        psl_q[CLS_PSL_CC_HI:CLS_PSL_CC_LO] <= aif.cc;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      done_q <= 1'b0;
      ill_q  <= 1'b0;
    end
    else
    begin
      done_q <= last;
      ill_q  <= state_q == CLS_IDLE && start && !legal_d;
    end
  end

  assign reg0              = regs_q[0];
  assign reg1              = regs_q[1];
  assign reg2              = regs_q[2];
  assign reg3              = regs_q[3];
  assign lower_status      = psl_q;
  assign upper_status_byte = psu_q;
  assign busy              = state_q == CLS_EXEC;
  assign done              = done_q;
  assign running           = state_q != CLS_WAIT;
  assign illegal           = ill_q;

  // busy for every cycle of the instruction, then a single done cycle
  sequence cls_busy2_s;
    busy [*2] ##1 (done && !busy);
  endsequence : cls_busy2_s
  sequence cls_busy3_s;
    busy [*3] ##1 (done && !busy);
  endsequence : cls_busy3_s
  sequence cls_busy4_s;
    busy [*4] ##1 (done && !busy);
  endsequence : cls_busy4_s

  AST_HALT_WAIT: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == CLS_IDLE && start && opcode == CLS_OP_HALT) |-> ##3 !running)
    else $error("halt did not enter wait");
  AST_HALT_LEN: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == CLS_IDLE && start && opcode == CLS_OP_HALT) |-> ##1 cls_busy2_s)
    else $error("halt length wrong");
  AST_WAIT_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    (!running && !irq) |=> !running)
    else $error("left wait without interrupt");
  AST_WAIT_NOSTART: assert property (@(posedge clk) disable iff (!resetn)
    (!running && start && !irq) |=> !busy)
    else $error("start taken while waiting");
  AST_CMPZ_LEN: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == CLS_IDLE && start && opcode[7:2] == CLS_OP_COMPARE_Z) |-> ##1 cls_busy2_s)
    else $error("compare length wrong");
  AST_CMPZ_REGS: assert property (@(posedge clk) disable iff (!resetn)
    (last && opc_q[7:2] == CLS_OP_COMPARE_Z) |=> {reg3, reg2, reg1, reg0} == $past({reg3, reg2, reg1, reg0}))
    else $error("compare changed a register");
  AST_CMPZ_STATUS: assert property (@(posedge clk) disable iff (!resetn)
    (last && opc_q[7:2] == CLS_OP_COMPARE_Z) |=> (psl_q[5:0] == $past(psl_q[5:0]) && psu_q == $past(psu_q)))
    else $error("compare changed status beyond cc");
  AST_CMP_EQ: assert property (@(posedge clk) disable iff (!resetn)
    (last && opc_q[7:2] == CLS_OP_COMPARE_Z && regs_q[0] == regs_q[rsel])
    |=> psl_q[7:6] == CLS_CC_ZERO)
    else $error("equal compare cc wrong");
  AST_CMP_UNS: assert property (@(posedge clk) disable iff (!resetn)
    (last && opc_q[7:2] == CLS_OP_COMPARE_Z && psl_q[CLS_PSL_COM] && regs_q[0] > regs_q[rsel])
    |=> psl_q[7:6] == CLS_CC_POS)
    else $error("unsigned compare wrong");
  AST_CMP_SGN: assert property (@(posedge clk) disable iff (!resetn)
    (last && opc_q[7:2] == CLS_OP_COMPARE_Z && !psl_q[CLS_PSL_COM]
     && $signed(regs_q[0]) < $signed(regs_q[rsel])) |=> psl_q[7:6] == CLS_CC_NEG)
    else $error("signed compare wrong");
  AST_CLR_LEN: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == CLS_IDLE && start && (opcode == CLS_OP_CLR_LOWER || opcode == CLS_OP_CLR_UPPER))
    |-> ##1 cls_busy3_s)
    else $error("status clear length wrong");
  AST_CLR_MASK: assert property (@(posedge clk) disable iff (!resetn)
    (last && opc_q == CLS_OP_CLR_LOWER) |=> psl_q == ($past(psl_q) & ~$past(opd_q)))
    else $error("masked clear wrong");
  // unassigned upper bits 4 and 3 always read back as zero
  AST_CLR_UPPER: assert property (@(posedge clk) disable iff (!resetn)
    (last && opc_q == CLS_OP_CLR_UPPER) |=> psu_q == ($past(psu_q) & ~$past(opd_q) & CLS_PSU_USED))
    else $error("upper masked clear wrong");
  AST_CLR_REGS: assert property (@(posedge clk) disable iff (!resetn)
    (last && (opc_q == CLS_OP_CLR_LOWER || opc_q == CLS_OP_CLR_UPPER))
    |=> {reg3, reg2, reg1, reg0} == $past({reg3, reg2, reg1, reg0}))
    else $error("status clear changed a register");
  AST_DA_LEN: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == CLS_IDLE && start && opcode[7:2] == CLS_OP_DECADJ) |-> ##1 cls_busy3_s)
    else $error("decimal adjust length wrong");
  AST_DA_ADD: assert property (@(posedge clk) disable iff (!resetn)
    (last && opc_q[7:2] == CLS_OP_DECADJ && !psl_q[CLS_PSL_C] && !psl_q[CLS_PSL_IDC])
    |=> regs_q[rsel] == {4'($past(regs_q[rsel][7:4]) + CLS_DA_00[7:4]), 4'($past(regs_q[rsel][3:0]) + CLS_DA_00[3:0])})
    else $error("decimal adjust sum wrong");
  AST_DA_KEEP: assert property (@(posedge clk) disable iff (!resetn)
    (last && opc_q[7:2] == CLS_OP_DECADJ) |=> psl_q[5:0] == $past(psl_q[5:0]))
    else $error("decimal adjust changed carries");
  AST_DA_CC: assert property (@(posedge clk) disable iff (!resetn)
    (last && opc_q[7:2] == CLS_OP_DECADJ) |=> psl_q[7:6] == cls_cc_of(regs_q[rsel]))
    else $error("decimal adjust cc wrong");
  AST_ABS_LEN: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == CLS_IDLE && start && opcode[7:2] == CLS_OP_XOR_A) |-> ##1 cls_busy4_s)
    else $error("absolute length wrong");
  AST_OR_ABS_LEN: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == CLS_IDLE && start && opcode[7:2] == CLS_OP_OR_A) |-> ##1 cls_busy4_s)
    else $error("or absolute length wrong");
  AST_ABS_FETCH: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == CLS_IDLE && start && (opcode[7:2] == CLS_OP_XOR_A || opcode[7:2] == CLS_OP_OR_A))
    |-> ##3 fetch_req)
    else $error("absolute operand not fetched");
  AST_IDX_R0: assert property (@(posedge clk) disable iff (!resetn)
    (last && idx_q && opc_q[1:0] != 2'h0) |=> regs_q[rsel] == $past(regs_q[rsel]))
    else $error("indexed form wrote register r");
  AST_IMM_FETCH: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == CLS_IDLE && start && (opcode[7:2] == CLS_OP_XOR_I || opcode[7:2] == CLS_OP_OR_I))
    |=> fetch_req)
    else $error("immediate byte not fetched");
  AST_REL_LEN: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == CLS_IDLE && start && (opcode[7:2] == CLS_OP_XOR_R || opcode[7:2] == CLS_OP_OR_R))
    |-> ##1 cls_busy3_s)
    else $error("relative length wrong");
  AST_XORZ_R0: assert property (@(posedge clk) disable iff (!resetn)
    (last && opc_q[7:2] == CLS_OP_XOR_Z) |=> reg0 == ($past(regs_q[0]) ^ $past(regs_q[rsel])))
    else $error("xor to register zero wrong");
  AST_Z_KEEP: assert property (@(posedge clk) disable iff (!resetn)
    (last && cls_is_z(opc_q) && rsel != 2'h0) |=> regs_q[rsel] == $past(regs_q[rsel]))
    else $error("register-zero form changed register r");
  AST_Z_NOFETCH: assert property (@(posedge clk) disable iff (!resetn)
    (busy && cls_is_z(opc_q)) |-> !fetch_req)
    else $error("register-zero form fetched a byte");
  AST_LOGIC_CC: assert property (@(posedge clk) disable iff (!resetn)
    (last && cls_is_logic(opc_q)) |=> psl_q[7:6] == cls_cc_of(regs_q[dst]))
    else $error("logic cc wrong");
endmodule : cls_core

// [bench/cls_prog_mem.sv]
// program memory model: hands one operand byte per fetch
// assumes the byte is wanted in the same cycle as fetch_req
`timescale 1ns/1ps
module cls_prog_mem
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // fetch port
  input  wire logic       fetch_req,
  output logic [7:0]      fetch_data
);
  logic [7:0] next_q = 8'h00;
  logic [7:0] last_q;

  task automatic load(input logic [7:0] b);
    next_q = b;
  endtask : load

  // released bus shows the inverse, so a stale copy never passes
  assign fetch_data = fetch_req ? next_q : ~last_q;
  always_ff @(posedge clk)
  begin
    if (!resetn)
      last_q <= 8'h00;
    else if (fetch_req)
      last_q <= next_q;
  end
endmodule : cls_prog_mem

// [bench/test_compare_logic_status_ops.sv]
// self-checking bench for the compare / logic / status-op slice
// assumes cls_core and the program memory model cls_prog_mem
`timescale 1ns/1ps
module test_compare_logic_status_ops
  import cls_pkg::*;
;
  logic       clk;
  logic       resetn;
  logic       start;
  logic [7:0] opcode;
  logic       indexed;
  logic       fetch_req;
  logic [7:0] fetch_data;
  logic       irq;
  logic [7:0] reg0, reg1, reg2, reg3;
  logic [7:0] lower_status;
  logic [7:0] upper_status_byte;
  logic       busy, done, running, illegal;
  logic [7:0] rm [0:3];
  logic [7:0] ps;
  logic [7:0] pu;
  int         n;
  int         n_errors = 0;
  int         check_count = 0;

  cls_core u_cls_core (.clk(clk), .resetn(resetn), .start(start), .opcode(opcode), .indexed(indexed),
    .fetch_req(fetch_req), .fetch_data(fetch_data), .irq(irq), .reg0(reg0), .reg1(reg1), .reg2(reg2),
    .reg3(reg3), .lower_status(lower_status), .upper_status_byte(upper_status_byte), .busy(busy),
    .done(done), .running(running), .illegal(illegal));
  cls_prog_mem u_cls_prog_mem (.clk(clk), .resetn(resetn), .fetch_req(fetch_req), .fetch_data(fetch_data));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [1:0] ccof(input logic [7:0] v);
    return v[7] ? 2'h2 : (v == 8'h00) ? 2'h0 : 2'h1;
  endfunction : ccof

  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      n_errors++;
    end
  endtask : chk

  // inputs move 1 ns after the edge, never racing the sample
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step

  task automatic cmp_state;
    chk(reg0, rm[0], "reg0");
    chk(reg1, rm[1], "reg1");
    chk(reg2, rm[2], "reg2");
    chk(reg3, rm[3], "reg3");
    chk(lower_status, ps, "lower status");
    chk(upper_status_byte, pu, "upper status");
  endtask : cmp_state

  // returns with done high, so the next call issues back to back
  task automatic exec(input logic [7:0] op, input logic idx, input logic [7:0] data, input int nc);
    u_cls_prog_mem.load(data);
    start = 1'b1;
    opcode = op;
    indexed = idx;
    step();
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 8)
    begin
      chk(8'(busy), 8'h1, "busy");
      step();
      n++;
    end
    chk(8'(n), 8'(nc), "cycle count");
    if (n == 8) conclude();
  endtask : exec

  task automatic lop(input logic [7:0] op, input logic idx, input logic [7:0] data);
    logic [1:0] m;
    int         d;
    logic [7:0] v;
    m = op[3:2];
    d = (m == 2'h0 || (m == 2'h3 && idx)) ? 0 : int'(op[1:0]);
    v = (m == 2'h0) ? rm[op[1:0]] : data;
    v = op[6] ? (rm[d] | v) : (rm[d] ^ v);
    exec(op, idx, data, (m == 2'h3) ? 4 : (m == 2'h2) ? 3 : 2);
    rm[d] = v;
    ps[7:6] = ccof(v);
    cmp_state();
  endtask : lop

  task automatic cmpz(input logic [1:0] r);
    exec(8'he0 | 8'(r), 1'b0, 8'h00, 2);
    ps[7:6] = (ps[1] ? (rm[0] > rm[r]) : ($signed(rm[0]) > $signed(rm[r]))) ? 2'h1
              : (rm[0] == rm[r]) ? 2'h0 : 2'h2;
    cmp_state();
  endtask : cmpz

  // nibbles wrap on their own, no carry between them
  task automatic dadj(input logic [1:0] r);
    logic [7:0] a;
    a = {ps[0] ? 4'h0 : 4'ha, ps[5] ? 4'h0 : 4'ha};
    exec(8'h94 | 8'(r), 1'b0, 8'h00, 3);
    rm[r] = {rm[r][7:4] + a[7:4], rm[r][3:0] + a[3:0]};
    ps[7:6] = ccof(rm[r]);
    cmp_state();
  endtask : dadj

  task automatic clrs(input logic [7:0] op, input logic [7:0] mask);
    exec(op, 1'b0, mask, 3);
    if (op[0])
      ps = ps & ~mask;
    else
      pu = pu & ~mask;
    cmp_state();
  endtask : clrs

  task automatic wait_run(input logic want);
    n = 0;
    while (running !== want && n < 8)
    begin
      step();
      n++;
    end
    if (n == 8)
    begin
      $display("[FAIL] %0t run state did not change", $time);
      n_errors++;
      conclude();
    end
  endtask : wait_run

  task automatic halt;
    start = 1'b1;
    opcode = 8'h40;
    step();
    start = 1'b0;
    wait_run(1'b0);
    chk(8'(n), 8'h2, "halt latency");
  endtask : halt

  initial
  begin
    start = 1'b0;
    opcode = 8'h00;
    indexed = 1'b0;
    irq = 1'b0;
    resetn = 1'b0;
    rm = '{default: 8'h00};
    ps = 8'h00;
    pu = 8'h00;
    repeat (20) step();
    resetn = 1'b1;
    cmp_state();
    chk(8'(running), 8'h1, "running after reset");
    lop(8'h24, 1'b0, 8'h85);
    lop(8'h25, 1'b0, 8'h3c);
    lop(8'h26, 1'b0, 8'h00);
    lop(8'h27, 1'b0, 8'hf0);
    lop(8'h29, 1'b0, 8'h3c);
    lop(8'h6a, 1'b0, 8'h81);
    lop(8'h2e, 1'b0, 8'h7f);
    lop(8'h2d, 1'b1, 8'h0f);
    lop(8'h6f, 1'b0, 8'h0c);
    lop(8'h6d, 1'b1, 8'h01);
    lop(8'h65, 1'b0, 8'h42);
    lop(8'h23, 1'b0, 8'h00);
    lop(8'h20, 1'b0, 8'h00);
    lop(8'h64, 1'b0, 8'h90);
    lop(8'h27, 1'b0, 8'h7c);
    for (int i = 0; i < 4; i++) cmpz(2'(i));
    for (int i = 0; i < 4; i++) dadj(2'(i));
    clrs(8'h75, 8'h80);
    clrs(8'h75, 8'h40);
    clrs(8'h74, 8'hff);
    start = 1'b1;
    opcode = 8'hc0;
    step();
    start = 1'b0;
    n = 0;
    while (illegal !== 1'b1 && n < 4)
    begin
      step();
      n++;
    end
    chk(8'(illegal), 8'h1, "illegal flag");
    if (n == 4) conclude();
    cmp_state();
    halt();
    // a start in wait must be dropped, not queued
    u_cls_prog_mem.load(8'hff);
    start = 1'b1;
    opcode = 8'h24;
    repeat (4) step();
    start = 1'b0;
    cmp_state();
    chk(8'(running), 8'h0, "still waiting");
    irq = 1'b1;
    step();
    irq = 1'b0;
    wait_run(1'b1);
    chk(8'(running), 8'h1, "wake on interrupt");
    halt();
    resetn = 1'b0;
    repeat (2) step();
    resetn = 1'b1;
    rm = '{default: 8'h00};
    ps = 8'h00;
    pu = 8'h00;
    cmp_state();
    chk(8'(running), 8'h1, "wake on reset");
    lop(8'h25, 1'b0, 8'h01);
    conclude();
  end
endmodule : test_compare_logic_status_ops
